// >>> rtl/pir_pkg.sv
package pir_pkg;
  // image geometry
  localparam int CHANS = 2;
  localparam int BYTE_W = 8;
  localparam int DATA_W = 16;
  localparam int IMG_BYTES = 6;
  localparam int IMG_BYTES_ALIGNED = 8;
  localparam int IMG_W = BYTE_W * IMG_BYTES_ALIGNED;
  localparam int CH_STRIDE_U = 3;
  localparam int CH_STRIDE_A = 4;
  localparam int WORD_OFS_U = 1;
  localparam int WORD_OFS_A = 2;

  // control and status byte fields
  localparam int MODE_BIT = 7;
  localparam int RW_BIT = 6;
  localparam int ERR_BIT = 6;
  localparam int REGNO_W = 6;
  localparam logic PD_ACK = 1'h0;
  localparam logic REG_ACK = 1'h1;
  localparam logic RW_WRITE = 1'h1;
  localparam logic [BYTE_W-1:0] MODE_MASK = 8'h80;
  localparam logic [REGNO_W-1:0] DIAG_REG = 6'h06;
  localparam logic [BYTE_W-1:0] DIAG_RSVD = 8'h00;
  localparam logic [DATA_W-1:0] AO_RESET = 16'h0000;

  typedef enum logic [1:0] {
    LIM_OFF = 2'b00,
    LIM_BELOW = 2'b01,
    LIM_ABOVE = 2'b10,
    LIM_EQUAL = 2'b11
  } pir_lim_type;

  // host register map, one aligned word each
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;
  localparam int AXI_STRB_W = AXI_DATA_W / BYTE_W;
  localparam logic [AXI_ADDR_W-1:0] REG_CH_OUT0 = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] REG_CH_IN0 = 8'h08;
  localparam logic [AXI_ADDR_W-1:0] REG_RUN = 8'h10;
  localparam logic [AXI_ADDR_W-1:0] CH_REG_STRIDE = 8'h04;
  localparam int RUN_BIT = 0;
  localparam int CNT_LSB = 16;
  localparam int CNT_W = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;

  // exchange period
  localparam int CLK_PERIOD_PS = 25000;
  localparam int EXCH_PERIOD_NS = 1000;
  localparam int EXCH_CYCLES = (EXCH_PERIOD_NS * 1000) / CLK_PERIOD_PS;

  typedef enum logic {
    HS_IDLE = 1'b0,
    HS_WAIT = 1'b1
  } pir_hst_state_type;

  function automatic int pir_ofs(input bit aligned, input int ch, input bit word);
    int ofs;
    ofs = aligned ? CH_STRIDE_A * ch : CH_STRIDE_U * ch;
    if (word) begin
      ofs = ofs + (aligned ? WORD_OFS_A : WORD_OFS_U);
    end
    return ofs;
  endfunction

  function automatic pir_lim_type pir_lim(input logic en, input logic signed [DATA_W-1:0] v,
                                          input logic signed [DATA_W-1:0] t);
    pir_lim_type r;
    if (!en) begin
      r = LIM_OFF;
    end else if (v < t) begin
      r = LIM_BELOW;
    end else if (v > t) begin
      r = LIM_ABOVE;
    end else begin
      r = LIM_EQUAL;
    end
    return r;
  endfunction
endpackage

// >>> rtl/pir_img_if.sv
`timescale 1ns/1ps
interface pir_img_if
  import pir_pkg::*;
();
  // output image, controller to device
  logic [IMG_W-1:0] out_img;
  logic xfer;
  // input image, device to controller
  logic [IMG_W-1:0] in_img;
  logic in_valid;

  modport dev (
    input out_img,
    input xfer,
    output in_img,
    output in_valid
  );

  modport host (
    output out_img,
    output xfer,
    input in_img,
    input in_valid
  );
endinterface

// >>> rtl/pir_dev_end.sv
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
module pir_dev_end
  import pir_pkg::*;
#(
  parameter bit WORD_ALIGN = 1'b0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // process image link
  pir_img_if.dev img,
  // analog input side, per channel
  input wire logic [CHANS-1:0][DATA_W-1:0] proc_word,
  input wire logic [CHANS-1:0] err_flag,
  input wire logic [CHANS-1:0] over_flag,
  input wire logic [CHANS-1:0] under_flag,
  // limit settings, per channel, index 0 first limit
  input wire logic [CHANS-1:0][1:0] lim_en,
  input wire logic [CHANS-1:0][1:0][DATA_W-1:0] lim_val,
  // analog output side, per channel
  output logic [CHANS-1:0][DATA_W-1:0] ao_word,
  // parameter register port, per channel
  output logic [CHANS-1:0][REGNO_W-1:0] reg_addr,
  output logic [CHANS-1:0] reg_wr,
  output logic [CHANS-1:0][DATA_W-1:0] reg_wdata,
  input wire logic [CHANS-1:0][DATA_W-1:0] reg_rdata
);

  // two-stage answer: the control byte is latched first so that
  // reg_addr is settled a full cycle before reg_rdata is sampled
  logic stage_q;
  logic in_valid_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stage_q <= 1'b0;
    end else begin
      stage_q <= img.xfer;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      in_valid_q <= 1'b0;
    end else begin
      in_valid_q <= stage_q;
    end
  end

  assign img.in_valid = in_valid_q;

  logic [CHANS-1:0][BYTE_W-1:0] stat_all;
  logic [CHANS-1:0][DATA_W-1:0] din_all;

  for (genvar c = 0; c < CHANS; c++) begin : g_ch
    localparam int CO = pir_ofs(WORD_ALIGN, c, 1'b0);
    localparam int WO = pir_ofs(WORD_ALIGN, c, 1'b1);

    logic [BYTE_W-1:0] cb;
    logic [DATA_W-1:0] ow;
    logic [BYTE_W-1:0] pd_stat;
    logic [BYTE_W-1:0] ctrl_q;
    logic [BYTE_W-1:0] stat_q;
    logic [DATA_W-1:0] din_q;
    logic [DATA_W-1:0] wdata_q;
    logic [DATA_W-1:0] ao_q;
    logic wr_q;
    pir_lim_type lim1;
    pir_lim_type lim2;
    logic cb_reg;
    logic cb_wr;
    logic is_reg;
    logic is_wr;
    logic is_diag;

    // each channel picks its own bytes out of the image
    assign cb = img.out_img[BYTE_W*CO +: BYTE_W];
    assign ow = img.out_img[BYTE_W*WO +: DATA_W];

    // decode of the arriving byte and of the byte latched for the answer
    assign cb_reg = cb[MODE_BIT];
    assign cb_wr = cb[RW_BIT] == RW_WRITE;
    assign is_reg = ctrl_q[MODE_BIT];
    assign is_wr = ctrl_q[RW_BIT] == RW_WRITE;
    assign is_diag = ctrl_q[REGNO_W-1:0] == DIAG_REG;

    always_comb begin
      lim1 = pir_lim(lim_en[c][0], proc_word[c], lim_val[c][0]);
      lim2 = pir_lim(lim_en[c][1], proc_word[c], lim_val[c][1]);
    end

    // process-data status, also the diagnostic register low byte
    always_comb begin
      pd_stat = {PD_ACK,
                 err_flag[c],
                 lim2,
                 lim1,
                 over_flag[c],
                 under_flag[c]};
    end

    // latched in every mode so reg_addr always names the last request
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        ctrl_q <= '0;
      end else if (img.xfer) begin
        ctrl_q <= cb;
      end
    end

    // analog output word only follows the image in process mode
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        ao_q <= AO_RESET;
      end else if (img.xfer && !cb_reg) begin
        ao_q <= ow;
      end
    end

    // a held write request is repeated on every exchange
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        wr_q <= 1'b0;
      end else begin
        wr_q <= img.xfer && cb_reg && cb_wr;
      end
    end

    always_ff @(posedge ref_clk) begin
      if (rst) begin
        wdata_q <= '0;
      end else if (img.xfer && cb_reg) begin
        wdata_q <= ow;
      end
    end

    always_ff @(posedge ref_clk) begin
      if (rst) begin
        stat_q <= '0;
      end else if (stage_q) begin
        if (is_reg) begin
          stat_q <= {REG_ACK,
                     ctrl_q[RW_BIT],
                     ctrl_q[REGNO_W-1:0]};
        end else begin
          stat_q <= pd_stat;
        end
      end
    end

    // diagnostic reads are served here so they never wait on reg_rdata
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        din_q <= '0;
      end else if (stage_q) begin
        if (!is_reg) begin
          din_q <= proc_word[c];
        end else if (is_wr) begin
          // a write answers with the value taken
          din_q <= wdata_q;
        end else if (is_diag) begin
          din_q <= {DIAG_RSVD, pd_stat};
        end else begin
          din_q <= reg_rdata[c];
        end
      end
    end

    assign stat_all[c] = stat_q;
    assign din_all[c] = din_q;
    assign ao_word[c] = ao_q;
    assign reg_addr[c] = ctrl_q[REGNO_W-1:0];
    assign reg_wr[c] = wr_q;
    assign reg_wdata[c] = wdata_q;
  end

  // input image: unused bytes and alignment gaps read as zero
  always_comb begin
    img.in_img = '0;
    for (int c = 0; c < CHANS; c++) begin
      img.in_img[BYTE_W*pir_ofs(WORD_ALIGN, c, 1'b0) +: BYTE_W] = stat_all[c];
      img.in_img[BYTE_W*pir_ofs(WORD_ALIGN, c, 1'b1) +: DATA_W] = din_all[c];
    end
  end

endmodule

// >>> rtl/pir_axil.sv
`timescale 1ns/1ps
module pir_axil
  import pir_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // write address and data
  input wire logic [AXI_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [AXI_DATA_W-1:0] wdata,
  input wire logic [AXI_STRB_W-1:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read address and data
  input wire logic [AXI_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [AXI_DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // register file side
  output logic wr_en,
  output logic [AXI_ADDR_W-1:0] wr_addr,
  output logic [AXI_DATA_W-1:0] wr_data,
  output logic [AXI_STRB_W-1:0] wr_strb,
  output logic [AXI_ADDR_W-1:0] rd_addr,
  input wire logic [AXI_DATA_W-1:0] rd_data
);

  logic aw_hold_q, w_hold_q, awready_q, wready_q, bvalid_q, wr_en_q;
  logic arready_q, rvalid_q;
  logic aw_take, w_take, go, ar_take;
  logic aw_hold_d, w_hold_d, bvalid_d, rvalid_d;
  logic [AXI_ADDR_W-1:0] addr_q;
  logic [AXI_DATA_W-1:0] wdata_q, rdata_q;
  logic [AXI_STRB_W-1:0] strb_q;

  // address and data may arrive in either order; ready stays low
  // until the response is taken, so one write is under way at most
  always_comb begin
    aw_take = awvalid && awready_q;
    w_take = wvalid && wready_q;
    go = aw_hold_q && w_hold_q && !bvalid_q;
    aw_hold_d = go ? 1'b0 : (aw_hold_q || aw_take);
    w_hold_d = go ? 1'b0 : (w_hold_q || w_take);
    bvalid_d = go || (bvalid_q && !bready);
    ar_take = arvalid && arready_q;
    rvalid_d = ar_take || (rvalid_q && !rready);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      wr_en_q <= 1'b0;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      awready_q <= !aw_hold_d && !bvalid_d;
      wready_q <= !w_hold_d && !bvalid_d;
      bvalid_q <= bvalid_d;
      wr_en_q <= go;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      addr_q <= '0;
      wdata_q <= '0;
      strb_q <= '0;
    end else begin
      if (aw_take) begin
        addr_q <= awaddr;
      end
      if (w_take) begin
        wdata_q <= wdata;
        strb_q <= wstrb;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      arready_q <= !rvalid_d;
      rvalid_q <= rvalid_d;
      if (ar_take) begin
        rdata_q <= rd_data;
      end
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = RESP_OKAY;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = RESP_OKAY;
  assign wr_en = wr_en_q;
  assign wr_addr = addr_q;
  assign wr_data = wdata_q;
  assign wr_strb = strb_q;
  assign rd_addr = araddr;

endmodule

// >>> rtl/pir_host_end.sv
`timescale 1ns/1ps
module pir_host_end
  import pir_pkg::*;
#(
  parameter bit WORD_ALIGN = 1'b0,
  parameter int EXCH_DIV = EXCH_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // software register bus
  input wire logic [AXI_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [AXI_DATA_W-1:0] wdata,
  input wire logic [AXI_STRB_W-1:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AXI_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [AXI_DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // process image link
  pir_img_if.host img
);

  logic wr_en;
  logic [AXI_ADDR_W-1:0] wr_addr, rd_addr;
  logic [AXI_DATA_W-1:0] wr_data, rd_data;
  logic [AXI_STRB_W-1:0] wr_strb;
  logic [CHANS-1:0][AXI_DATA_W-1:0] out_q, in_q;
  logic [AXI_DATA_W-1:0] run_q;
  logic [CNT_W-1:0] cnt_q;
  logic [$clog2(EXCH_DIV+1)-1:0] div_q;
  logic tick, xfer_q;
  pir_hst_state_type state_q;

  pir_axil i_pir_axil (
    .ref_clk(ref_clk), .rst(rst),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .wr_strb(wr_strb),
    .rd_addr(rd_addr), .rd_data(rd_data)
  );

  // byte lanes honoured on every writable word
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      out_q <= '0;
      run_q <= '0;
    end else if (wr_en) begin
      for (int b = 0; b < AXI_STRB_W; b++) begin
        for (int c = 0; c < CHANS; c++) begin
          if (wr_strb[b] && wr_addr == REG_CH_OUT0 + AXI_ADDR_W'(c) * CH_REG_STRIDE) begin
            out_q[c][BYTE_W*b +: BYTE_W] <= wr_data[BYTE_W*b +: BYTE_W];
          end
        end
        if (wr_strb[b] && wr_addr == REG_RUN) begin
          run_q[BYTE_W*b +: BYTE_W] <= wr_data[BYTE_W*b +: BYTE_W];
        end
      end
    end
  end

  always_comb begin
    rd_data = '0;
    for (int c = 0; c < CHANS; c++) begin
      if (rd_addr == REG_CH_OUT0 + AXI_ADDR_W'(c) * CH_REG_STRIDE) begin
        rd_data = out_q[c];
      end
      if (rd_addr == REG_CH_IN0 + AXI_ADDR_W'(c) * CH_REG_STRIDE) begin
        rd_data = in_q[c];
      end
    end
    if (rd_addr == REG_RUN) begin
      rd_data[RUN_BIT] = run_q[RUN_BIT];
      rd_data[CNT_LSB +: CNT_W] = cnt_q;
    end
  end

  // exchange rate divider
  always_ff @(posedge ref_clk) begin
    if (rst || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  assign tick = (div_q == ($bits(div_q))'(EXCH_DIV - 1));

  // a tick during an unanswered exchange is dropped, not queued
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= HS_IDLE;
      xfer_q <= 1'b0;
      cnt_q <= '0;
      in_q <= '0;
    end else begin
      xfer_q <= 1'b0;
      unique case (state_q)
        HS_IDLE: begin
          if (tick && run_q[RUN_BIT]) begin
            xfer_q <= 1'b1;
            state_q <= HS_WAIT;
          end
        end
        HS_WAIT: begin
          if (img.in_valid) begin
            for (int c = 0; c < CHANS; c++) begin
              in_q[c] <= {{(AXI_DATA_W - BYTE_W - DATA_W){1'b0}},
                img.in_img[BYTE_W*pir_ofs(WORD_ALIGN, c, 1'b1) +: DATA_W],
                img.in_img[BYTE_W*pir_ofs(WORD_ALIGN, c, 1'b0) +: BYTE_W]};
            end
            cnt_q <= cnt_q + 1'b1;
            state_q <= HS_IDLE;
          end
        end
      endcase
    end
  end

  assign img.xfer = xfer_q;

  // output image built from the channel words
  always_comb begin
    img.out_img = '0;
    for (int c = 0; c < CHANS; c++) begin
      // process mode sends the unused control bits as zero
      img.out_img[BYTE_W*pir_ofs(WORD_ALIGN, c, 1'b0) +: BYTE_W] =
        out_q[c][MODE_BIT] ? out_q[c][BYTE_W-1:0]
                           : (out_q[c][BYTE_W-1:0] & MODE_MASK);
      img.out_img[BYTE_W*pir_ofs(WORD_ALIGN, c, 1'b1) +: DATA_W] =
        out_q[c][BYTE_W +: DATA_W];
    end
  end

endmodule

// >>> bench/pir_img_monitor.sv
`timescale 1ns/1ps
module pir_img_monitor
  import pir_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // image link
  input wire logic [IMG_W-1:0] out_img,
  input wire logic xfer,
  input wire logic [IMG_W-1:0] in_img,
  input wire logic in_valid
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // byte positions assume the unaligned image, channel two at byte 3
  sequence s_reg1;
    xfer && out_img[7];
  endsequence
  sequence s_reg2;
    xfer && out_img[31];
  endsequence
  sequence s_pd1;
    xfer && !out_img[7];
  endsequence
  sequence s_pd2;
    xfer && !out_img[31];
  endsequence

  property p_answer;
    xfer |-> ##2 in_valid;
  endproperty
  property p_no_spur;
    in_valid |-> $past(xfer, 2);
  endproperty
  property p_pulse;
    in_valid |=> !in_valid;
  endproperty
  property p_stay;
    $changed(in_img) |-> in_valid || $past(rst);
  endproperty
  property p_pad;
    (xfer |-> out_img[63:48] == 16'h0000) and (in_valid |-> in_img[63:48] == 16'h0000);
  endproperty
  property p_echo1;
    s_reg1 |-> ##2 in_img[7:0] == {REG_ACK, $past(out_img[6:0], 2)};
  endproperty
  property p_echo2;
    s_reg2 |-> ##2 in_img[31:24] == {REG_ACK, $past(out_img[30:24], 2)};
  endproperty
  property p_pd1;
    s_pd1 |-> ##2 in_img[7] == PD_ACK;
  endproperty
  property p_pd2;
    s_pd2 |-> ##2 in_img[31] == PD_ACK;
  endproperty
  property p_mask;
    s_pd1 |-> out_img[6:0] == 7'h00;
  endproperty

  a_answer: assert property (p_answer)
    else $error("no answer two cycles after exchange");
  a_no_spur: assert property (p_no_spur)
    else $error("answer without exchange");
  a_pulse: assert property (p_pulse)
    else $error("answer strobe longer than one cycle");
  a_stay: assert property (p_stay)
    else $error("input image changed without answer");
  a_pad: assert property (p_pad)
    else $error("image bytes beyond six not zero");
  a_echo1: assert property (p_echo1)
    else $error("channel one register acknowledge wrong");
  a_echo2: assert property (p_echo2)
    else $error("channel two register acknowledge wrong");
  a_pd1: assert property (p_pd1)
    else $error("channel one process acknowledge wrong");
  a_pd2: assert property (p_pd2)
    else $error("channel two process acknowledge wrong");
  a_mask: assert property (p_mask)
    else $error("process mode control bits not zero");
endmodule

// >>> bench/test_process_image_register_access.sv
`timescale 1ns/1ps
module test_process_image_register_access
  import pir_pkg::*;
();
  typedef struct packed {
    logic [7:0] ctrl;
    logic [15:0] ow;
    logic [15:0] pw;
    logic [2:0] fl;
    logic [1:0] en;
    logic [15:0] l1;
    logic [15:0] l2;
    logic [7:0] es;
    logic [15:0] ew;
  } pir_tb_row_type;

  // control, out word, process value, err/over/under, limit enables, limits, status, in word
  localparam pir_tb_row_type ROWS [7] = '{
    '{8'h00, 16'h1234, 16'h0100, 3'h0, 2'h3, 16'h0100, 16'h0200, 8'h1C, 16'h0100},
    '{8'h7F, 16'hFFFF, 16'h8000, 3'h7, 2'h1, 16'h0000, 16'h0000, 8'h47, 16'h8000},
    '{8'h86, 16'h0000, 16'h7FFF, 3'h2, 2'h2, 16'h0000, 16'h7FFE, 8'h86, 16'h0022},
    '{8'hBF, 16'h5555, 16'h0000, 3'h0, 2'h0, 16'h0000, 16'h0000, 8'hBF, 16'hC03F},
    '{8'hC1, 16'hBEEF, 16'h0000, 3'h0, 2'h0, 16'h0000, 16'h0000, 8'hC1, 16'hBEEF},
    '{8'h80, 16'h0000, 16'h0000, 3'h0, 2'h0, 16'h0000, 16'h0000, 8'h80, 16'hC000},
    '{8'h00, 16'h0000, 16'hFFFF, 3'h1, 2'h3, 16'hFFFF, 16'h0000, 8'h1D, 16'hFFFF}
  };

  logic ref_clk, rst;
  logic [AXI_ADDR_W-1:0] awaddr, araddr;
  logic [AXI_DATA_W-1:0] wdata, rdata, d, e, rdata2, d2;
  logic [AXI_STRB_W-1:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic awready2, wready2, bvalid2, arready2, rvalid2;
  logic [1:0] bresp, rresp, bresp2, rresp2, seen;
  logic [3:0] last_bresp, last_rresp;
  logic [CHANS-1:0][DATA_W-1:0] proc_word, ao_word, reg_wdata, reg_rdata;
  logic [CHANS-1:0][DATA_W-1:0] ao_word2, reg_wdata2, reg_rdata2;
  logic [CHANS-1:0] err_flag, over_flag, under_flag, reg_wr, reg_wr2;
  logic [CHANS-1:0][1:0] lim_en;
  logic [CHANS-1:0][1:0][DATA_W-1:0] lim_val;
  logic [CHANS-1:0][REGNO_W-1:0] reg_addr, reg_addr2;
  int fail_count, comparisons, ix[2];
  pir_tb_row_type r;

  // far register file: the value carries its number, so a wrong address shows up
  always_comb begin
    for (int c = 0; c < CHANS; c++) begin
      reg_rdata[c] = {10'h300, reg_addr[c]};
      reg_rdata2[c] = {10'h300, reg_addr2[c]};
    end
  end

  pir_img_if i_pir_img_if ();
  pir_dev_end #(.WORD_ALIGN(1'b0)) i_pir_dev_end (.ref_clk(ref_clk), .rst(rst),
    .img(i_pir_img_if), .proc_word(proc_word), .err_flag(err_flag), .over_flag(over_flag),
    .under_flag(under_flag), .lim_en(lim_en), .lim_val(lim_val), .ao_word(ao_word),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  // short exchange period keeps the run brief
  pir_host_end #(.WORD_ALIGN(1'b0), .EXCH_DIV(4)) i_pir_host_end (.ref_clk(ref_clk), .rst(rst),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .img(i_pir_img_if));
  // word-aligned pair on the same bus inputs; it runs in lockstep with the first pair
  pir_img_if i_pir_img_if_aligned ();
  pir_dev_end #(.WORD_ALIGN(1'b1)) i_pir_dev_end_aligned (.ref_clk(ref_clk), .rst(rst),
    .img(i_pir_img_if_aligned), .proc_word(proc_word), .err_flag(err_flag),
    .over_flag(over_flag), .under_flag(under_flag), .lim_en(lim_en), .lim_val(lim_val),
    .ao_word(ao_word2), .reg_addr(reg_addr2), .reg_wr(reg_wr2), .reg_wdata(reg_wdata2),
    .reg_rdata(reg_rdata2));
  pir_host_end #(.WORD_ALIGN(1'b1), .EXCH_DIV(4)) i_pir_host_end_aligned (.ref_clk(ref_clk),
    .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready2), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready2), .bresp(bresp2), .bvalid(bvalid2),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready2),
    .rdata(rdata2), .rresp(rresp2), .rvalid(rvalid2), .rready(rready),
    .img(i_pir_img_if_aligned));
  pir_img_monitor i_pir_img_monitor (.ref_clk(ref_clk), .rst(rst),
    .out_img(i_pir_img_if.out_img), .xfer(i_pir_img_if.xfer),
    .in_img(i_pir_img_if.in_img), .in_valid(i_pir_img_if.in_valid));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic summarize();
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tmo();
    fail_count++;
    $display("BAD wait expected answer seen none");
    summarize();
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    logic pa, pd;
    int n;
    pa = 1'b1;
    pd = 1'b1;
    n = 0;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (pa && awready) begin
        pa = 1'b0;
        awvalid <= 1'b0;
      end
      if (pd && wready) begin
        pd = 1'b0;
        wvalid <= 1'b0;
      end
    end while (!(bvalid && !pa && !pd) && n < 100);
    last_bresp = {bresp2, bresp};
    bready <= 1'b0;
    if (n >= 100) tmo();
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] v);
    logic pa;
    int n;
    pa = 1'b1;
    n = 0;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (pa && arready) begin
        pa = 1'b0;
        arvalid <= 1'b0;
      end
    end while (!(rvalid && !pa) && n < 100);
    v = rdata;
    d2 = rdata2;
    last_rresp = {rresp2, rresp};
    rready <= 1'b0;
    if (n >= 100) tmo();
  endtask

  // static on purpose: automatic indices are not allowed on nonblocking targets
  task apply(input int c, input pir_tb_row_type rw);
    proc_word[c] <= rw.pw;
    err_flag[c] <= rw.fl[2];
    over_flag[c] <= rw.fl[1];
    under_flag[c] <= rw.fl[0];
    lim_en[c] <= rw.en;
    lim_val[c] <= {rw.l2, rw.l1};
    axw(REG_CH_OUT0 + 8'(c) * CH_REG_STRIDE, {8'h00, rw.ow, rw.ctrl});
  endtask

  // two exchanges: the first may have sampled the image before the last write
  task automatic sync();
    logic [31:0] v;
    logic [15:0] c0;
    int n;
    axr(REG_RUN, v);
    c0 = v[31:16];
    n = 0;
    do begin
      axr(REG_RUN, v);
      n++;
    end while (16'(v[31:16] - c0) < 16'd2 && n < 100);
    if (n >= 100) tmo();
  endtask

  initial begin
    rst = 1'b1;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hF;
    {proc_word, err_flag, over_flag, under_flag, lim_en, lim_val} = '0;
    fail_count = 0;
    comparisons = 0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("reset image", {i_pir_img_if.in_img}, 64'h0);
    chk("reset strobes", {i_pir_img_if.xfer, i_pir_img_if.in_valid, reg_wr}, 64'h0);
    chk("reset outputs", {ao_word, reg_addr}, 64'h0);
    axr(REG_RUN, d);
    chk("reset run", d, 64'h0);
    axw(8'h40, 32'hFFFF_FFFF);
    chk("unmapped resp", last_bresp, {RESP_OKAY, RESP_OKAY});
    axr(8'h40, d);
    chk("unmapped read", {d2, d}, 64'h0);
    chk("read resp", last_rresp, {RESP_OKAY, RESP_OKAY});
    axw(REG_RUN, 32'h0000_0001);
    for (int i = 0; i < 7; i++) begin
      ix[0] = i;
      ix[1] = (i + 3) % 7;
      for (int c = 0; c < CHANS; c++) apply(c, ROWS[ix[c]]);
      sync();
      for (int c = 0; c < CHANS; c++) begin
        r = ROWS[ix[c]];
        axr(REG_CH_IN0 + 8'(c) * CH_REG_STRIDE, d);
        chk("input reg", d, {8'h00, r.ew, r.es});
        chk("aligned input reg", d2, {8'h00, r.ew, r.es});
        if (!r.ctrl[MODE_BIT]) chk("output word", ao_word[c], r.ow);
        if (!r.ctrl[MODE_BIT]) chk("aligned word", ao_word2[c], r.ow);
        if (r.ctrl[7:6] == 2'b11) begin
          chk("write port", {reg_wdata[c], reg_addr[c]}, {r.ow, r.ctrl[5:0]});
          chk("aligned port", {reg_wdata2[c], reg_addr2[c]}, {r.ow, r.ctrl[5:0]});
        end
        // two exchanges fit in eight cycles, so a held write must pulse at least once
        seen = '0;
        repeat (8) begin
          @(posedge ref_clk);
          seen = seen | {reg_wr2[c], reg_wr[c]};
        end
        chk("write strobe", seen, {2{r.ctrl[7:6] == 2'b11}});
      end
    end
    axw(REG_RUN, 32'h0000_0000);
    axr(REG_RUN, d);
    axr(REG_RUN, d);
    repeat (3) axr(REG_RUN, e);
    chk("halted count", e, d);
    axw(REG_RUN, 32'h0000_0001);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("rerun outputs", {ao_word2, ao_word}, 64'h0);
    chk("rerun image", {i_pir_img_if.in_img}, 64'h0);
    chk("rerun bus", {awready, wready, arready, bvalid, rvalid}, 64'h1C);
    chk("rerun bus2", {awready2, wready2, arready2, bvalid2, rvalid2}, 64'h1C);
    axr(REG_RUN, d);
    chk("rerun run", d, 64'h0);
    summarize();
  end
endmodule
